/* File: logic/rpbm_defines.svh */
// Opcode values, flag positions, reset values and step sizes.
`ifndef RPBM_DEFINES_SVH
`define RPBM_DEFINES_SVH

// Prefix bytes.
`define RPBM_OPC_REP_EQUAL 8'hf3
`define RPBM_OPC_REP_UNEQUAL 8'hf2
`define RPBM_OPC_WHILE_CARRY 8'hf6
`define RPBM_OPC_UNTIL_CARRY 8'hf7

// Block opcodes in bits 7 to 1; bit 0 is the word select.
`define RPBM_OPC_MOVE 7'h52
`define RPBM_OPC_COMPARE 7'h53
`define RPBM_OPC_SCAN 7'h57
`define RPBM_WORD_BIT 0

// Flag vector bit positions.
`define RPBM_FLAG_V 5
`define RPBM_FLAG_S 4
`define RPBM_FLAG_Z 3
`define RPBM_FLAG_AC 2
`define RPBM_FLAG_P 1
`define RPBM_FLAG_CY 0
`define RPBM_FLAGS_W 6

// Source segment override selectors.
`define RPBM_SEG_SOURCE 2'h0
`define RPBM_SEG_DEST 2'h1
`define RPBM_SEG_STACK 2'h2
`define RPBM_SEG_PROGRAM 2'h3

// Reset values and index steps.
`define RPBM_FLAGS_RST 6'h00
`define RPBM_WORD_RST 16'h0000
`define RPBM_ADDR_RST 20'h00000
`define RPBM_STEP_BYTE 16'h0001
`define RPBM_STEP_WORD 16'h0002
`define RPBM_ONE 16'h0001
`define RPBM_ADDR_ONE 20'h00001

`endif

/* File: logic/rpbm_pkg.sv */
// Types shared by the repeat and block move logic.
package rpbm_pkg;

	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_PREFIX = 7'h02,
		ST_TEST = 7'h04,
		ST_SRC = 7'h08,
		ST_DST = 7'h10,
		ST_STEP = 7'h20,
		ST_DONE = 7'h40
	} rpbm_state_e;

	typedef enum logic [2:0]
	{
		RK_NONE = 3'h0,
		RK_EQUAL = 3'h1,
		RK_UNEQUAL = 3'h2,
		RK_CARRY = 3'h3,
		RK_NOCARRY = 3'h4
	} rpbm_repeat_e;

	typedef enum logic [1:0]
	{
		OK_MOVE = 2'h0,
		OK_COMPARE = 2'h1,
		OK_SCAN = 2'h2,
		OK_OTHER = 2'h3
	} rpbm_op_e;

endpackage

/* File: logic/rpbm_mem_seq.sv */
// Byte-wide memory access sequencer for byte and word elements.
`timescale 1ns/1ps
`include "rpbm_defines.svh"

module rpbm_mem_seq #(
	parameter int ADDR_W = 20
) (
	input wire logic clk, // Core clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic start, // One-cycle request to begin an element.
	input wire logic word, // High for a two-byte element.
	input wire logic write, // High to write, low to read.
	input wire logic [ADDR_W-1:0] addr, // Element start address.
	input wire logic [15:0] wdata, // Element to write.
	output logic [15:0] rdata, // Element read back.
	output logic done, // One-cycle pulse at element end.
	output logic memReq, // Byte access request.
	output logic memWrite, // Byte access is a write.
	output logic [ADDR_W-1:0] memAddr, // Byte address.
	output logic [7:0] memWdata, // Byte to write.
	input wire logic [7:0] memRdata, // Byte read.
	input wire logic memAck // Memory takes the current byte.
);

	logic highPhase_q;
	logic wordPend_q;
	logic [7:0] highByte_q;

	if (ADDR_W != 20)
	begin : g_chk
		$error("rpbm_mem_seq supports a 20-bit physical address only");
	end

	// Low byte goes first at the element address, high byte one above it,
	// so words keep little-endian order in memory.
	// little-endian byte pairing
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			memReq <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= `RPBM_ADDR_RST;
			memWdata <= 8'h00;
			highPhase_q <= 1'b0;
			wordPend_q <= 1'b0;
			highByte_q <= 8'h00;
			rdata <= `RPBM_WORD_RST;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !memReq)
			begin
				memReq <= 1'b1;
				memWrite <= write;
				memAddr <= addr;
				memWdata <= wdata[7:0];
				highByte_q <= wdata[15:8];
				wordPend_q <= word;
				highPhase_q <= 1'b0;
			end
			else if (memReq && memAck)
			begin
				if (!highPhase_q)
				begin
					rdata[7:0] <= memRdata;
				end
				else
				begin
					rdata[15:8] <= memRdata;
				end
				if (!highPhase_q && wordPend_q)
				begin
					highPhase_q <= 1'b1;
					memAddr <= memAddr + `RPBM_ADDR_ONE;
					memWdata <= highByte_q;
				end
				else
				begin
					memReq <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule

/* File: logic/rpbm_top.sv */
// Repeat prefix sequencer and primitive block move/compare engine.
`timescale 1ns/1ps
`include "rpbm_defines.svh"

// How it works
// - each pass runs once, then count decrements
// - zero count on entry skips the instruction
// - while-carry loop stops when carry clear
// - until-carry loop stops when carry set
// - only fresh comparison flags are tested
// - plain repeat tests only the count
// - while-equal stops on zero clear or count
// - while-unequal stops on zero set or count
// - byte f3 is repeat, equal with compares
// - byte f2 is repeat while unequal
// - move opcode bits 7..1, bit0 word
// - read source, write destination, step indexes
// - direction flag picks increment or decrement
// - destination always uses destination segment
// - source segment defaults, override allowed
// - element size fixed by opcode word bit
// - comparisons update all six flags
module rpbm_top #(
	parameter int ADDR_W = 20
) (
	input wire logic clk, // Core clock, 20 MHz.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic instrValid, // Instruction byte offered.
	input wire logic [7:0] instrByte, // Instruction byte.
	output logic instrReady, // Byte accepted this cycle if valid.
	output logic instrDone, // Pulse when an instruction ends.
	output logic busy, // Instruction in progress.
	input wire logic loadRegs, // Load registers below, idle only.
	input wire logic [15:0] loadCount, // New repeat counter.
	input wire logic [15:0] loadSourceIndex, // New source index.
	input wire logic [15:0] loadDestIndex, // New destination index.
	input wire logic [5:0] loadFlags, // New flag vector.
	input wire logic directionFlag, // High to step indexes downward.
	input wire logic segOverrideValid, // Source segment override present.
	input wire logic [1:0] segOverrideSel, // Override segment select.
	input wire logic [15:0] sourceDataSegment, // Default source segment.
	input wire logic [15:0] destinationDataSegment, // Destination segment.
	input wire logic [15:0] stackSegment, // Stack segment.
	input wire logic [15:0] programSegment, // Program segment.
	input wire logic [15:0] accumulatorFull, // Accumulator for scans.
	output logic [15:0] repeatCounter, // Repeat counter.
	output logic [15:0] sourceIndex, // Source index.
	output logic [15:0] destinationIndex, // Destination index.
	output logic [5:0] flags, // Flags: V S Z AC P CY.
	output logic memReq, // Byte access request.
	output logic memWrite, // Byte access is a write.
	output logic [ADDR_W-1:0] memAddr, // Byte address.
	output logic [7:0] memWdata, // Byte to write.
	input wire logic [7:0] memRdata, // Byte read.
	input wire logic memAck // Memory takes the current byte.
);
	import rpbm_pkg::*;

	rpbm_state_e state_q;
	rpbm_repeat_e repKind_q;
	rpbm_op_e opKind_q;
	logic word_q;
	logic [1:0] srcSeg_q;
	logic [15:0] count_q;
	logic [15:0] srcIdx_q;
	logic [15:0] dstIdx_q;
	logic [5:0] flags_q;
	logic [15:0] srcData_q;
	logic ready_q;
	logic busy_q;
	logic done_q;
	logic seqStart_q;
	logic seqWrite_q;
	logic [ADDR_W-1:0] seqAddr_q;
	logic [15:0] seqWdata_q;
	logic [15:0] seqRdata;
	logic seqDone;
	logic stopLoop;
	logic [15:0] srcSegVal;
	rpbm_op_e decOp;

	if (ADDR_W != 20)
	begin : g_chk
		$error("rpbm_top supports a 20-bit physical address only");
	end

	// Segment base shifted by four plus offset, wrapping in 20 bits.
	function automatic logic [19:0] physAddr(input logic [15:0] seg,
		input logic [15:0] off);
		physAddr = {seg, 4'h0} + {4'h0, off};
	endfunction

	// One element step in the direction the flag chooses.
	function automatic logic [15:0] stepIndex(input logic [15:0] idx,
		input logic wrd, input logic down);
		logic [15:0] delta;
		delta = wrd ? `RPBM_STEP_WORD : `RPBM_STEP_BYTE;
		stepIndex = down ? idx - delta : idx + delta;
	endfunction

	// Flags of a minus b, at byte or word width.
	function automatic logic [5:0] cmpFlags(input logic [15:0] a,
		input logic [15:0] b, input logic wrd);
		logic [16:0] diff;
		logic [5:0] f;
		logic sa;
		logic sb;
		logic sd;
		diff = {1'b0, a} - {1'b0, b};
		f = 6'h00;
		if (wrd)
		begin
			sa = a[15];
			sb = b[15];
			sd = diff[15];
			f[`RPBM_FLAG_Z] = (diff[15:0] == 16'h0000);
			f[`RPBM_FLAG_CY] = diff[16];
		end
		else
		begin
			sa = a[7];
			sb = b[7];
			sd = diff[7];
			f[`RPBM_FLAG_Z] = (diff[7:0] == 8'h00);
			f[`RPBM_FLAG_CY] = a[7:0] < b[7:0];
		end
		f[`RPBM_FLAG_S] = sd;
		f[`RPBM_FLAG_V] = (sa != sb) && (sd != sa);
		f[`RPBM_FLAG_AC] = a[3:0] < b[3:0];
		f[`RPBM_FLAG_P] = ~^diff[7:0];
		cmpFlags = f;
	endfunction

	// Decode of a block opcode byte; bit 0 alone fixes the size.
	// block opcode decode
	always_comb
	begin
		unique case (instrByte[7:1])
			`RPBM_OPC_MOVE: decOp = OK_MOVE;
			`RPBM_OPC_COMPARE: decOp = OK_COMPARE;
			`RPBM_OPC_SCAN: decOp = OK_SCAN;
			default: decOp = OK_OTHER;
		endcase
	end

	// Source segment: default unless an override was captured.
	// source segment select
	always_comb
	begin
		unique case (srcSeg_q)
			`RPBM_SEG_SOURCE: srcSegVal = sourceDataSegment;
			`RPBM_SEG_DEST: srcSegVal = destinationDataSegment;
			`RPBM_SEG_STACK: srcSegVal = stackSegment;
			default: srcSegVal = programSegment;
		endcase
	end

	// Loop exit test on the flags the pass just produced, never on older
	// ones; plain repeat with a move ignores the zero flag altogether.
	// fresh flags only
	always_comb
	begin
		stopLoop = 1'b0;
		if (opKind_q != OK_MOVE)
		begin
			unique case (repKind_q)
				RK_EQUAL: stopLoop = !flags_q[`RPBM_FLAG_Z];
				RK_UNEQUAL: stopLoop = flags_q[`RPBM_FLAG_Z];
				RK_CARRY: stopLoop = !flags_q[`RPBM_FLAG_CY];
				RK_NOCARRY: stopLoop = flags_q[`RPBM_FLAG_CY];
				default: stopLoop = 1'b0;
			endcase
		end
	end

	// Sequencer and memory request issue. A byte that is neither prefix
	// nor handled block opcode ends the instruction with no effect.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= ST_IDLE;
			repKind_q <= RK_NONE;
			opKind_q <= OK_OTHER;
			word_q <= 1'b0;
			srcSeg_q <= `RPBM_SEG_SOURCE;
			ready_q <= 1'b1;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			seqStart_q <= 1'b0;
			seqWrite_q <= 1'b0;
			seqAddr_q <= `RPBM_ADDR_RST;
			seqWdata_q <= `RPBM_WORD_RST;
			srcData_q <= `RPBM_WORD_RST;
		end
		else
		begin
			done_q <= 1'b0;
			seqStart_q <= 1'b0;
			unique case (state_q)
				ST_IDLE, ST_PREFIX:
				begin
					if (instrValid)
					begin
						if (state_q == ST_IDLE)
						begin
							srcSeg_q <= segOverrideValid ? segOverrideSel
								: `RPBM_SEG_SOURCE;
							repKind_q <= RK_NONE;
						end
						if (instrByte == `RPBM_OPC_REP_EQUAL)
						begin
							repKind_q <= RK_EQUAL;
							state_q <= ST_PREFIX;
						end
						else if (instrByte == `RPBM_OPC_REP_UNEQUAL)
						begin
							repKind_q <= RK_UNEQUAL;
							state_q <= ST_PREFIX;
						end
						else if (instrByte == `RPBM_OPC_WHILE_CARRY)
						begin
							repKind_q <= RK_CARRY;
							state_q <= ST_PREFIX;
						end
						else if (instrByte == `RPBM_OPC_UNTIL_CARRY)
						begin
							repKind_q <= RK_NOCARRY;
							state_q <= ST_PREFIX;
						end
						else if (decOp != OK_OTHER)
						begin
							opKind_q <= decOp;
							word_q <= instrByte[`RPBM_WORD_BIT];
							ready_q <= 1'b0;
							busy_q <= 1'b1;
							state_q <= ST_TEST;
						end
						else
						begin
							ready_q <= 1'b0;
							busy_q <= 1'b1;
							state_q <= ST_DONE;
						end
					end
				end
				ST_TEST:
				begin
					if (repKind_q != RK_NONE && count_q == `RPBM_WORD_RST)
					begin
						state_q <= ST_DONE;
					end
					else if (opKind_q == OK_SCAN)
					begin
						seqStart_q <= 1'b1;
						seqWrite_q <= 1'b0;
						seqAddr_q <= physAddr(destinationDataSegment, dstIdx_q);
						state_q <= ST_DST;
					end
					else
					begin
						seqStart_q <= 1'b1;
						seqWrite_q <= 1'b0;
						seqAddr_q <= physAddr(srcSegVal, srcIdx_q);
						state_q <= ST_SRC;
					end
				end
				ST_SRC:
				begin
					if (seqDone)
					begin
						srcData_q <= seqRdata;
						seqStart_q <= 1'b1;
						seqWrite_q <= (opKind_q == OK_MOVE);
						seqWdata_q <= seqRdata;
						seqAddr_q <= physAddr(destinationDataSegment, dstIdx_q);
						state_q <= ST_DST;
					end
				end
				ST_DST:
				begin
					if (seqDone)
					begin
						state_q <= ST_STEP;
					end
				end
				ST_STEP:
				begin
					if (repKind_q != RK_NONE && !stopLoop)
					begin
						state_q <= ST_TEST;
					end
					else
					begin
						state_q <= ST_DONE;
					end
				end
				ST_DONE:
				begin
					done_q <= 1'b1;
					ready_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Comparison flags follow every compared element; loads only at idle.
	// comparison flag update
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flags_q <= `RPBM_FLAGS_RST;
		end
		else if (state_q == ST_DST && seqDone && opKind_q == OK_COMPARE)
		begin
			flags_q <= cmpFlags(srcData_q, seqRdata, word_q);
		end
		else if (state_q == ST_DST && seqDone && opKind_q == OK_SCAN)
		begin
			flags_q <= cmpFlags(accumulatorFull, seqRdata, word_q);
		end
		else if (loadRegs && state_q == ST_IDLE)
		begin
			flags_q <= loadFlags;
		end
	end

	// Index stepping after each element; a scan touches only the
	// destination index.
	// direction flag stepping
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			srcIdx_q <= `RPBM_WORD_RST;
			dstIdx_q <= `RPBM_WORD_RST;
		end
		else if (state_q == ST_STEP)
		begin
			if (opKind_q != OK_SCAN)
			begin
				srcIdx_q <= stepIndex(srcIdx_q, word_q, directionFlag);
			end
			dstIdx_q <= stepIndex(dstIdx_q, word_q, directionFlag);
		end
		else if (loadRegs && state_q == ST_IDLE)
		begin
			srcIdx_q <= loadSourceIndex;
			dstIdx_q <= loadDestIndex;
		end
	end

	// Repeat counter drops by one after each repeated pass.
	// count decrement
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count_q <= `RPBM_WORD_RST;
		end
		else if (state_q == ST_STEP && repKind_q != RK_NONE)
		begin
			count_q <= count_q - `RPBM_ONE;
		end
		else if (loadRegs && state_q == ST_IDLE)
		begin
			count_q <= loadCount;
		end
	end

	rpbm_mem_seq #(
		.ADDR_W(ADDR_W)
	) u_seq (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(seqStart_q),
		.word(word_q),
		.write(seqWrite_q),
		.addr(seqAddr_q),
		.wdata(seqWdata_q),
		.rdata(seqRdata),
		.done(seqDone),
		.memReq(memReq),
		.memWrite(memWrite),
		.memAddr(memAddr),
		.memWdata(memWdata),
		.memRdata(memRdata),
		.memAck(memAck)
	);

	// Outputs taken straight from their registers.
	assign instrReady = ready_q;
	assign instrDone = done_q;
	assign busy = busy_q;
	assign repeatCounter = count_q;
	assign sourceIndex = srcIdx_q;
	assign destinationIndex = dstIdx_q;
	assign flags = flags_q;

endmodule

/* File: verification/rpbm_monitor.sv */
// Port checker for the repeat and block move engine.
`timescale 1ns/1ps
module rpbm_monitor #(
	parameter int ADDR_W = 20
) (
	input wire logic clk, // Core clock.
	input wire logic sys_rst, // Async reset.
	input wire logic busy, // Instruction running.
	input wire logic loadRegs, // Register load.
	input wire logic directionFlag, // Step down when high.
	input wire logic [15:0] destinationDataSegment, // Dst segment.
	input wire logic [15:0] repeatCounter, // Counter.
	input wire logic [15:0] destinationIndex, // Dst index.
	input wire logic [5:0] flags, // Flag vector.
	input wire logic memReq, // Byte request.
	input wire logic memWrite, // Byte write.
	input wire logic [ADDR_W-1:0] memAddr, // Byte address.
	input wire logic memAck // Byte taken.
);
	logic [ADDR_W-1:0] wrOff;

	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Offset of a write from the destination base; a word may add one.
	assign wrOff = memAddr - ADDR_W'({destinationDataSegment, 4'h0})
		- ADDR_W'(destinationIndex);

	AST_COUNT_STEP: assert property ($past(busy) && repeatCounter !=
		$past(repeatCounter) |-> repeatCounter == $past(repeatCounter) - 16'h1)
		else $error("counter moved by other than one");
	AST_ZERO_HOLD: assert property ($past(busy) && $past(repeatCounter) == 0
		|-> repeatCounter == 16'h0)
		else $error("zero counter changed");
	AST_DST_UP: assert property ($past(busy) && !directionFlag &&
		$changed(destinationIndex) |->
		(destinationIndex - $past(destinationIndex)) inside {1, 2})
		else $error("destination index bad upward step");
	AST_DST_DOWN: assert property ($past(busy) && directionFlag &&
		$changed(destinationIndex) |->
		($past(destinationIndex) - destinationIndex) inside {1, 2})
		else $error("destination index bad downward step");
	AST_WRITE_ADDR: assert property (memReq && memWrite |-> wrOff <= 1)
		else $error("write outside destination element");
	AST_FLAGS_QUIET: assert property ($changed(flags) |->
		$past(busy) || $past(loadRegs))
		else $error("flags changed outside an instruction");
	AST_ZERO_RESULT: assert property ($past(busy) && $changed(flags) &&
		flags[3] |-> flags == 6'h0a)
		else $error("zero result with wrong flags");
	AST_REQ_HOLD: assert property (memReq && !memAck |=>
		memReq && $stable(memAddr) && $stable(memWrite))
		else $error("request dropped before ack");
	AST_REQ_BUSY: assert property (memReq |-> busy)
		else $error("memory request while idle");
endmodule

bind rpbm_top rpbm_monitor #(.ADDR_W(ADDR_W)) rpbm_monitor_i (
	.clk(clk),
	.sys_rst(sys_rst),
	.busy(busy),
	.loadRegs(loadRegs),
	.directionFlag(directionFlag),
	.destinationDataSegment(destinationDataSegment),
	.repeatCounter(repeatCounter),
	.destinationIndex(destinationIndex),
	.flags(flags),
	.memReq(memReq),
	.memWrite(memWrite),
	.memAddr(memAddr),
	.memAck(memAck)
);

/* File: verification/rpbm_mem_model.sv */
// Byte memory that answers the block engine after a set wait.
`timescale 1ns/1ps
module rpbm_mem_model (
	input wire logic clk, // Core clock.
	input wire logic memReq, // Byte request.
	input wire logic memWrite, // Byte write.
	input wire logic [19:0] memAddr, // Byte address.
	input wire logic [7:0] memWdata, // Byte to store.
	input wire logic [3:0] delay, // Wait cycles before ack.
	output logic [7:0] memRdata, // Byte read.
	output logic memAck // Byte taken.
);
	logic [7:0] mem [0:1048575];
	logic [3:0] waitCnt;

	initial
	begin
		memAck = 1'b0;
		waitCnt = 4'h0;
	end

	// Ack drops after each byte so a held request is never taken twice.
	always @(posedge clk)
	begin
		if (memReq && memAck)
		begin
			if (memWrite)
				mem[memAddr] <= memWdata;
			memAck <= 1'b0;
			waitCnt <= 4'h0;
		end
		else if (memReq && waitCnt >= delay)
			memAck <= 1'b1;
		else if (memReq)
			waitCnt <= waitCnt + 4'h1;
	end

	// Outside an ack the data bus shows a moving pattern, not old data.
	assign memRdata = memAck ? mem[memAddr] : {4'ha, waitCnt};
endmodule

/* File: verification/rpbm_top_test.sv */
// Self-checking bench for the repeat and block move engine.
`timescale 1ns/1ps
module rpbm_top_test;
	import rpbm_pkg::*;
	logic clk, sys_rst, instrValid, instrReady, instrDone, busy, loadRegs;
	logic directionFlag, segOverrideValid, memReq, memWrite, memAck;
	logic [7:0] instrByte, memWdata, memRdata;
	logic [15:0] loadCount, loadSourceIndex, loadDestIndex, accumulatorFull;
	logic [15:0] srcSeg, dstSeg, stkSeg, prgSeg;
	logic [15:0] repeatCounter, sourceIndex, destinationIndex;
	logic [5:0] loadFlags, flags;
	logic [1:0] segOverrideSel;
	logic [19:0] memAddr;
	logic [3:0] memDelay;
	int bad_count = 0;
	int checked = 0;

	rpbm_top rpbm_top_i (.clk(clk), .sys_rst(sys_rst),
		.instrValid(instrValid), .instrByte(instrByte),
		.instrReady(instrReady), .instrDone(instrDone), .busy(busy),
		.loadRegs(loadRegs), .loadCount(loadCount),
		.loadSourceIndex(loadSourceIndex), .loadDestIndex(loadDestIndex),
		.loadFlags(loadFlags), .directionFlag(directionFlag),
		.segOverrideValid(segOverrideValid), .segOverrideSel(segOverrideSel),
		.sourceDataSegment(srcSeg), .destinationDataSegment(dstSeg),
		.stackSegment(stkSeg), .programSegment(prgSeg),
		.accumulatorFull(accumulatorFull), .repeatCounter(repeatCounter),
		.sourceIndex(sourceIndex), .destinationIndex(destinationIndex),
		.flags(flags), .memReq(memReq), .memWrite(memWrite),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
		.memAck(memAck));

	rpbm_mem_model rpbm_mem_model_i (.clk(clk), .memReq(memReq),
		.memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
		.delay(memDelay), .memRdata(memRdata), .memAck(memAck));

	// Free-running core clock.
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic put(input logic [19:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			rpbm_mem_model_i.mem[a + 20'(i)] = v[8*i +: 8];
	endtask

	function automatic logic [7:0] mb(input logic [19:0] a);
		return rpbm_mem_model_i.mem[a];
	endfunction

	// Load registers, feed optional prefix and block byte, await the end.
	task automatic run(input logic [7:0] pre, input logic [7:0] op,
		input logic [15:0] cnt, input logic [15:0] si,
		input logic [15:0] di, input logic [5:0] fl, input logic [2:0] ov);
		int n;
		n = 0;
		@(posedge clk);
		loadRegs <= 1'b1;
		loadCount <= cnt;
		loadSourceIndex <= si;
		loadDestIndex <= di;
		loadFlags <= fl;
		@(posedge clk);
		loadRegs <= 1'b0;
		segOverrideValid <= ov[2];
		segOverrideSel <= ov[1:0];
		instrValid <= 1'b1;
		if (pre != 8'h00)
		begin
			instrByte <= pre;
			@(posedge clk);
		end
		instrByte <= op;
		@(posedge clk);
		instrValid <= 1'b0;
		segOverrideValid <= 1'b0;
		while (!instrDone && n < 500)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(20'(n < 500), 20'h1);
	endtask

	task automatic t_reset();
		chk({instrReady, busy, memReq, flags}, 20'h100);
		chk(repeatCounter, 20'h0);
	endtask

	task automatic t_word_move();
		put(20'h03010, 32'h44332211);
		memDelay <= 4'h3;
		run(8'hf3, 8'ha5, 16'h2, 16'h10, 16'h20, 6'h00, 3'b110);
		for (int i = 0; i < 4; i++)
			chk(mb(20'h02020 + 20'(i)), 20'(8'h11 * (i + 1)));
		chk({sourceIndex, 4'h0}, {16'h14, 4'h0});
		chk(destinationIndex, 20'h24);
		chk(repeatCounter, 20'h0);
		chk(flags, 20'h0);
		memDelay <= 4'h0;
	endtask

	task automatic t_byte_down();
		put(20'h0102c, 32'h0a0b0c0d);
		put(20'h0203c, 32'h0);
		@(posedge clk);
		directionFlag <= 1'b1;
		run(8'hf3, 8'ha4, 16'h3, 16'h2f, 16'h3f, 6'h00, 3'b000);
		@(posedge clk);
		directionFlag <= 1'b0;
		for (int i = 0; i < 3; i++)
			chk(mb(20'h0203f - 20'(i)), 20'h0a + 20'(i));
		chk(mb(20'h0203c), 20'h0);
		chk(sourceIndex, 20'h2c);
		chk(destinationIndex, 20'h3c);
	endtask

	task automatic t_zero_single();
		put(20'h01050, 32'h99999999);
		put(20'h02050, 32'h77777777);
		run(8'hf3, 8'ha4, 16'h0, 16'h50, 16'h50, 6'h00, 3'b000);
		chk(mb(20'h02050), 20'h77);
		chk(sourceIndex, 20'h50);
		run(8'h00, 8'ha4, 16'h5, 16'h50, 16'h50, 6'h00, 3'b000);
		chk(mb(20'h02050), 20'h99);
		chk(repeatCounter, 20'h5);
		// A byte that is no handled opcode must leave the repeat counter and source index alone.
		run(8'h00, 8'h90, 16'h7, 16'h50, 16'h50, 6'h00, 3'b000);
		chk(repeatCounter, 20'h7);
		chk(sourceIndex, 20'h50);
	endtask

	task automatic t_compare();
		put(20'h01060, 32'h04030201);
		put(20'h02060, 32'h04090201);
		run(8'hf3, 8'ha6, 16'h5, 16'h60, 16'h60, 6'h00, 3'b000);
		chk(repeatCounter, 20'h2);
		chk(flags, 20'h17);
		chk(sourceIndex, 20'h63);
		@(posedge clk);
		accumulatorFull <= 16'h0041;
		put(20'h02070, 32'h00004110);
		run(8'hf2, 8'hae, 16'h5, 16'h70, 16'h70, 6'h08, 3'b000);
		chk(repeatCounter, 20'h3);
		chk({destinationIndex, flags}, {16'h72, 6'h0a});
	endtask

	task automatic t_carry();
		put(20'h01080, 32'h00010501);
		put(20'h02080, 32'h00020202);
		run(8'hf6, 8'ha6, 16'h3, 16'h80, 16'h80, 6'h00, 3'b000);
		chk(repeatCounter, 20'h1);
		chk(flags, 20'h02);
		put(20'h01090, 32'h00000105);
		put(20'h02090, 32'h00000202);
		run(8'hf7, 8'ha6, 16'h4, 16'h90, 16'h90, 6'h01, 3'b000);
		chk(repeatCounter, 20'h2);
		chk(sourceIndex, 20'h92);
	endtask

	// Hang guard, well beyond the few hundred cycles the tests need.
	initial
	begin
		#(20000 * 50);
		bad_count++;
		finish_test();
	end

	// Main sequence.
	initial
	begin
		{instrValid, loadRegs, directionFlag, segOverrideValid} = 4'h0;
		{instrByte, segOverrideSel, loadFlags, memDelay} = 0;
		{loadCount, loadSourceIndex, loadDestIndex, accumulatorFull} = 0;
		{srcSeg, dstSeg, stkSeg, prgSeg} = 64'h0100_0200_0300_0400;
		sys_rst = 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		t_reset();
		t_word_move();
		t_byte_down();
		t_zero_single();
		t_compare();
		t_carry();
		finish_test();
	end
endmodule
